/* inc/dtc_pkg.sv */
// Purpose: Constants for the dual timer/counter and external irq flags
// Assumes: Byte-wide special function register bus, 25 MHz core clock
// Notes:   Mode register offset is a local choice
package dtc_pkg;
   localparam logic [7:0] DTC_ADDR_CTRL  = 8'h88;
   localparam logic [7:0] DTC_ADDR_MODE  = 8'h89;
   localparam logic [7:0] DTC_ADDR_A_LO  = 8'h8a;
   localparam logic [7:0] DTC_ADDR_B_LO  = 8'h8b;
   localparam logic [7:0] DTC_ADDR_A_HI  = 8'h8c;
   localparam logic [7:0] DTC_ADDR_B_HI  = 8'h8d;
   localparam logic [7:0] DTC_RST_BYTE   = 8'h00;
   // Control register bit positions
   localparam int DTC_B_OVF  = 7;
   localparam int DTC_B_RUN  = 6;
   localparam int DTC_A_OVF  = 5;
   localparam int DTC_A_RUN  = 4;
   localparam int DTC_XB_FLG = 3;
   localparam int DTC_XB_TT  = 2;
   localparam int DTC_XA_FLG = 1;
   localparam int DTC_XA_TT  = 0;
   // Mode register nibble layout: gate, select, mode[1:0]
   localparam int DTC_GATE = 3;
   localparam int DTC_SEL  = 2;
   localparam int DTC_NIB  = 4;
   // Machine cycle length in core clocks
   localparam int DTC_MC_CLKS = 12;
   localparam logic [3:0] DTC_MC_LAST = 4'(DTC_MC_CLKS - 1);
   localparam logic [7:0] DTC_PRE_MAX = 8'h1f;
   localparam logic [7:0] DTC_BYTE_MAX = 8'hff;
   typedef enum logic [1:0] {
      DTC_MODE_PRE13 = 2'b00,
      DTC_MODE_CAS16 = 2'b01,
      DTC_MODE_RELD8 = 2'b10,
      DTC_MODE_SPLIT = 2'b11
   } dtc_mode_type;
endpackage : dtc_pkg

/* sim/dtc_pin_model.sv */
// Purpose: Far-side model of the two count pins
// Assumes: Commands are taken at clk_in rising edges
// Notes:   Each level holds 24 clocks, two machine cycles
`timescale 1ns/100ps
module dtc_pin_model (
   // Clock, reset and burst command
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       go_in,
   input  wire logic       sel_in,
   input  wire logic [3:0] edges_in,
   // Count pins, idle high
   output logic      [1:0] pins_out
);
   logic [4:0] hc_q;
   logic [4:0] tr_q;
   logic       s_q;
   // Toggle the chosen pin, two toggles per falling edge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hc_q <= 5'h00;
         tr_q <= 5'h00;
         s_q <= 1'b0;
         pins_out <= 2'h3;
      end else if (go_in) begin
         tr_q <= {edges_in, 1'b0};
         s_q <= sel_in;
      end else if (tr_q != 5'h00) begin
         hc_q <= (hc_q == 5'h17) ? 5'h00 : hc_q + 5'h01;
         if (hc_q == 5'h17) begin
            pins_out[s_q] <= ~pins_out[s_q];
            tr_q <= tr_q - 5'h01;
         end
      end
   end
endmodule : dtc_pin_model

/* sim/tb.sv */
// Purpose: Self-checking bench for the dual timer/counter
// Assumes: 25 MHz clock, reads settle two edges after the address
// Notes:   Counts are read only while the timer is stopped, gated or held
`timescale 1ns/100ps
module tb;
   import dtc_pkg::*;
   logic       clk_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic       reg_wr_in = 1'b0;
   logic [7:0] reg_rdata_out;
   logic [3:0] acks = 4'h0;
   logic       ext_irq_a_pin_in = 1'b1;
   logic       ext_irq_b_pin_in = 1'b1;
   logic       go = 1'b0;
   logic       sel = 1'b0;
   logic [3:0] edges = 4'h0;
   logic [1:0] pins;
   logic [3:0] flags;
   logic [7:0] rv;
   logic [7:0] rg [7][3];
   logic [7:0] ov [6][8];
   int         mismatches = 0;
   int         check_count = 0;
   int         i;
   dtc_top u_dtc_top (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rdata_out, .ack_a_ovf_in(acks[0]),
      .ack_b_ovf_in(acks[1]), .ack_xa_in(acks[2]), .ack_xb_in(acks[3]),
      .timer_a_count_pin_in(pins[0]), .timer_b_count_pin_in(pins[1]),
      .ext_irq_a_pin_in, .ext_irq_b_pin_in, .timer_a_ovf_out(flags[0]),
      .timer_b_ovf_out(flags[1]), .ext_irq_a_out(flags[2]),
      .ext_irq_b_out(flags[3]));
   dtc_pin_model u_dtc_pin_model (.clk_in, .rst_n_in, .go_in(go),
      .sel_in(sel), .edges_in(edges), .pins_out(pins));
   // Clock
   always #20 clk_in = ~clk_in;
   ////////////////////////////////////////////////////////////////////////
   // Bus, pulse and compare tasks
   task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : cmp
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clk_in);
      reg_addr_in <= a;
      repeat (2) @(posedge clk_in);
      #1 rv = reg_rdata_out;
   endtask : rd
   task pulse(input int k);
      @(posedge clk_in);
      acks[k] <= 1'b1;
      @(posedge clk_in);
      acks[k] <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
   endtask : pulse
   task wt(input int k);
      for (int n = 0; n < 40 && flags[k] !== 1'b1; n++) @(posedge clk_in);
      #1 cmp("ovf", 8'h01, {7'h00, flags[k]});
   endtask : wt
   task finish_test;
      if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_in);
      mismatches++;
      finish_test();
   end
   // Main sequence
   initial begin
      rg = '{'{8'h88, 8'h05, 8'h05}, '{8'h89, 8'ha5, 8'ha5},
         '{8'h8a, 8'h3c, 8'h3c}, '{8'h8b, 8'hc3, 8'hc3},
         '{8'h8c, 8'h5a, 8'h5a}, '{8'h8d, 8'ha5, 8'ha5},
         '{8'h90, 8'h77, 8'h00}};
      // Mode, low addr, low, high addr, high, run, low after, high after
      ov = '{'{8'h01, 8'h8a, 8'hfe, 8'h8c, 8'hff, 8'h10, 8'h00, 8'h00},
         '{8'h20, 8'h8b, 8'hfe, 8'h8d, 8'h80, 8'h40, 8'h80, 8'h80},
         '{8'h00, 8'h8a, 8'h1e, 8'h8c, 8'hff, 8'h10, 8'h00, 8'h00},
         '{8'h10, 8'h8b, 8'hfe, 8'h8d, 8'hff, 8'h40, 8'h00, 8'h00},
         '{8'h02, 8'h8a, 8'hfe, 8'h8c, 8'h33, 8'h10, 8'h33, 8'h33},
         '{8'h00, 8'h8b, 8'h1e, 8'h8d, 8'hff, 8'h40, 8'h00, 8'h00}};
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 7; i++) begin
         wr(rg[i][0], rg[i][1]);
         rd(rg[i][0]);
         cmp("reg", rg[i][2], rv);
      end
      // Overflow in modes 0 to 2 on both timers; flag kept, then acknowledged
      for (i = 0; i < 6; i++) begin
         wr(DTC_ADDR_MODE, ov[i][0]);
         wr(ov[i][1], ov[i][2]);
         wr(ov[i][3], ov[i][4]);
         wr(DTC_ADDR_CTRL, ov[i][5]);
         repeat (11) @(posedge clk_in);
         #1 cmp("early", 8'h00, {7'h00, flags[i%2]});
         wt(i % 2);
         wr(DTC_ADDR_CTRL, ov[i][5] << 1);
         rd(ov[i][1]);
         cmp("lo", ov[i][6], rv);
         rd(ov[i][3]);
         cmp("hi", ov[i][7], rv);
         pulse(i % 2);
         cmp("ack", 8'h00, {7'h00, flags[i%2]});
      end
      // Second reset clears all registers
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 6; i++) begin
         rd(DTC_ADDR_CTRL + 8'(i));
         cmp("rst", DTC_RST_BYTE, rv);
      end
      // Gated timers with irq pins low, level irq flags
      wr(DTC_ADDR_MODE, 8'h99);
      ext_irq_a_pin_in <= 1'b0;
      ext_irq_b_pin_in <= 1'b0;
      wr(DTC_ADDR_CTRL, 8'h50);
      repeat (40) @(posedge clk_in);
      rd(DTC_ADDR_A_LO);
      cmp("gate_a", 8'h00, rv);
      rd(DTC_ADDR_B_LO);
      cmp("gate_b", 8'h00, rv);
      cmp("lvl", 8'h03, {6'h00, flags[3:2]});
      pulse(3);
      cmp("lvl_ack", 8'h01, {7'h00, flags[3]});
      @(posedge clk_in);
      ext_irq_a_pin_in <= 1'b1;
      ext_irq_b_pin_in <= 1'b1;
      repeat (36) @(posedge clk_in);
      wr(DTC_ADDR_CTRL, 8'h00);
      #1 cmp("lvl_off", 8'h00, {6'h00, flags[3:2]});
      rd(DTC_ADDR_B_LO);
      cmp("gate_on", 8'h01, {7'h00, rv inside {[2:4]}});
      rd(DTC_ADDR_A_LO);
      cmp("gate_on_a", 8'h01, {7'h00, rv inside {[2:4]}});
      // Event counting from the count pins
      wr(DTC_ADDR_MODE, 8'h55);
      wr(DTC_ADDR_A_LO, 8'h00);
      wr(DTC_ADDR_B_LO, 8'h00);
      wr(DTC_ADDR_CTRL, 8'h50);
      for (i = 0; i < 2; i++) begin
         go <= 1'b1;
         sel <= i[0];
         edges <= 4'(2 + i);
         @(posedge clk_in);
         go <= 1'b0;
         repeat (200) @(posedge clk_in);
      end
      wr(DTC_ADDR_CTRL, 8'h00);
      rd(DTC_ADDR_A_LO);
      cmp("cnt_a", 8'h02, rv);
      rd(DTC_ADDR_B_LO);
      cmp("cnt_b", 8'h03, rv);
      // Edge irq flags cleared by acknowledge while pins stay low
      wr(DTC_ADDR_CTRL, 8'h05);
      ext_irq_a_pin_in <= 1'b0;
      ext_irq_b_pin_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1 cmp("edge", 8'h03, {6'h00, flags[3:2]});
      pulse(2);
      pulse(3);
      cmp("edge_ack", 8'h00, {6'h00, flags[3:2]});
      @(posedge clk_in);
      ext_irq_a_pin_in <= 1'b1;
      ext_irq_b_pin_in <= 1'b1;
      // Split timer A, timer B held
      wr(DTC_ADDR_MODE, 8'h33);
      wr(DTC_ADDR_A_LO, 8'hfe);
      wr(DTC_ADDR_A_HI, 8'hfe);
      wr(DTC_ADDR_B_LO, 8'h10);
      wr(DTC_ADDR_CTRL, 8'h10);
      wt(0);
      rd(DTC_ADDR_A_HI);
      cmp("split_hi", 8'hfe, rv);
      wr(DTC_ADDR_CTRL, 8'h40);
      wt(1);
      rd(DTC_ADDR_B_LO);
      cmp("hold", 8'h10, rv);
      finish_test();
   end
endmodule : tb

/* src/dtc_top.sv */
// Purpose: Two 16-bit timer/counters and two external irq request flags
// Assumes: Inputs synchronous to clk_in; bus write is a one-cycle strobe
// Notes:   Vector acknowledges are one-cycle pulses from the core
`timescale 1ns/100ps
module dtc_top
   import dtc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Register bus
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   output logic      [7:0] reg_rdata_out,
   // Vector acknowledges from the core
   input  wire logic       ack_a_ovf_in,
   input  wire logic       ack_b_ovf_in,
   input  wire logic       ack_xa_in,
   input  wire logic       ack_xb_in,
   // Pins
   input  wire logic       timer_a_count_pin_in,
   input  wire logic       timer_b_count_pin_in,
   input  wire logic       ext_irq_a_pin_in,
   input  wire logic       ext_irq_b_pin_in,
   // Flags to the interrupt controller
   output logic            timer_a_ovf_out,
   output logic            timer_b_ovf_out,
   output logic            ext_irq_a_out,
   output logic            ext_irq_b_out
);
   import dtc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [3:0] mc_cnt_q, mc_cnt_d;
   logic       mc_tick;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] mode_q, mode_d;
   logic [7:0] lo_q [2], lo_d [2];
   logic [7:0] hi_q [2], hi_d [2];
   logic [1:0] cpin_q, cpin_d;
   logic [1:0] xpin_q, xpin_d;
   logic [7:0] rdata_q, rdata_d;

   ////////////////////////////////////////////////////////////////////////
   // Machine cycle divider
   always_comb begin
      mc_tick  = (mc_cnt_q == DTC_MC_LAST);
      mc_cnt_d = mc_tick ? 4'h0 : mc_cnt_q + 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Per timer enables and increments
   logic [1:0]  cpin_now;
   logic [1:0]  xpin_now;
   logic [1:0]  tmr_en;
   logic [1:0]  tmr_inc;
   logic [1:0]  ovf_evt;
   logic        ahi_inc;
   logic [7:0]  lo_nx [2];
   logic [7:0]  hi_nx [2];
   logic [1:0]  lo_wr, hi_wr;

   assign cpin_now = {timer_b_count_pin_in, timer_a_count_pin_in};
   assign xpin_now = {ext_irq_b_pin_in, ext_irq_a_pin_in};
   assign lo_wr = {reg_wr_in && reg_addr_in == DTC_ADDR_B_LO,
                   reg_wr_in && reg_addr_in == DTC_ADDR_A_LO};
   assign hi_wr = {reg_wr_in && reg_addr_in == DTC_ADDR_B_HI,
                   reg_wr_in && reg_addr_in == DTC_ADDR_A_HI};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_tmr
         logic [3:0]   nib;
         dtc_mode_type md;
         logic         run;
         logic         ev;
         assign nib = mode_q[gi*DTC_NIB +: DTC_NIB];
         assign md  = dtc_mode_type'(nib[1:0]);
         assign run = ctrl_q[gi ? DTC_B_RUN : DTC_A_RUN];
         // Gated by run bit and irq pin level
         assign tmr_en[gi] = run && (!nib[DTC_GATE] || xpin_now[gi]);
         // Pin falling between machine-cycle samples
         assign ev = nib[DTC_SEL] ? (cpin_q[gi] && !cpin_now[gi]) : 1'b1;
         // Source select
         assign tmr_inc[gi] = mc_tick && tmr_en[gi] && ev &&
                              !(gi == 1 && md == DTC_MODE_SPLIT);

         // Next count per mode
         always_comb begin
            lo_nx[gi]   = lo_q[gi];
            hi_nx[gi]   = hi_q[gi];
            ovf_evt[gi] = 1'b0;
            if (tmr_inc[gi]) begin
               case (md)
                  DTC_MODE_PRE13: begin
                     if (lo_q[gi][4:0] == DTC_PRE_MAX[4:0]) begin
                        lo_nx[gi] = {lo_q[gi][7:5], 5'h00};
                        hi_nx[gi] = hi_q[gi] + 8'h01;
                        ovf_evt[gi] = (hi_q[gi] == DTC_BYTE_MAX);
                     end else begin
                        lo_nx[gi] = lo_q[gi] + 8'h01;
                     end
                  end
                  DTC_MODE_CAS16: begin
                     lo_nx[gi] = lo_q[gi] + 8'h01;
                     if (lo_q[gi] == DTC_BYTE_MAX) begin
                        hi_nx[gi] = hi_q[gi] + 8'h01;
                        ovf_evt[gi] = (hi_q[gi] == DTC_BYTE_MAX);
                     end
                  end
                  DTC_MODE_RELD8: begin
                     if (lo_q[gi] == DTC_BYTE_MAX) begin
                        lo_nx[gi] = hi_q[gi];
                        ovf_evt[gi] = 1'b1;
                     end else begin
                        lo_nx[gi] = lo_q[gi] + 8'h01;
                     end
                  end
                  DTC_MODE_SPLIT: begin
                     lo_nx[gi] = lo_q[gi] + 8'h01;
                     ovf_evt[gi] = (lo_q[gi] == DTC_BYTE_MAX);
                  end
                  default: begin
                     lo_nx[gi] = lo_q[gi];
                  end
               endcase
            end
         end
      end
   endgenerate

   // Timer A high byte in split mode: machine cycles under B's run
   assign ahi_inc = mc_tick && ctrl_q[DTC_B_RUN] &&
                    (dtc_mode_type'(mode_q[1:0]) == DTC_MODE_SPLIT);

   ////////////////////////////////////////////////////////////////////////
   // Count, control and sample next values
   always_comb begin
      logic split_a;
      logic b_ovf_set;
      split_a = (dtc_mode_type'(mode_q[1:0]) == DTC_MODE_SPLIT);
      b_ovf_set = split_a ? (ahi_inc && hi_q[0] == DTC_BYTE_MAX)
                          : ovf_evt[1];
      for (int k = 0; k < 2; k++) begin
         lo_d[k] = lo_wr[k] ? reg_wdata_in : lo_nx[k];
         hi_d[k] = hi_wr[k] ? reg_wdata_in : hi_nx[k];
      end
      if (split_a && !hi_wr[0]) begin
         hi_d[0] = hi_q[0] + {7'h00, ahi_inc};
      end
      cpin_d = mc_tick ? cpin_now : cpin_q;
      xpin_d = xpin_now;
      mode_d = (reg_wr_in && reg_addr_in == DTC_ADDR_MODE) ?
               reg_wdata_in : mode_q;
      ctrl_d = (reg_wr_in && reg_addr_in == DTC_ADDR_CTRL) ?
               reg_wdata_in : ctrl_q;
      // Hardware clears on vector, sets win afterwards
      if (ack_a_ovf_in) ctrl_d[DTC_A_OVF] = 1'b0;
      if (ack_b_ovf_in) ctrl_d[DTC_B_OVF] = 1'b0;
      if (ovf_evt[0]) ctrl_d[DTC_A_OVF] = 1'b1;
      if (b_ovf_set) ctrl_d[DTC_B_OVF] = 1'b1;
      // Irq A: edge clears on vector, level follows pin
      if (ctrl_q[DTC_XA_TT]) begin
         if (ack_xa_in) ctrl_d[DTC_XA_FLG] = 1'b0;
         if (xpin_q[0] && !xpin_now[0]) ctrl_d[DTC_XA_FLG] = 1'b1;
      end else begin
         ctrl_d[DTC_XA_FLG] = !xpin_now[0];
      end
      // Irq B likewise
      if (ctrl_q[DTC_XB_TT]) begin
         if (ack_xb_in) ctrl_d[DTC_XB_FLG] = 1'b0;
         if (xpin_q[1] && !xpin_now[1]) ctrl_d[DTC_XB_FLG] = 1'b1;
      end else begin
         ctrl_d[DTC_XB_FLG] = !xpin_now[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, live values, registered
   always_comb begin
      if (reg_addr_in == DTC_ADDR_CTRL) begin
         rdata_d = ctrl_q;
      end else if (reg_addr_in == DTC_ADDR_MODE) begin
         rdata_d = mode_q;
      end else if (reg_addr_in == DTC_ADDR_A_LO) begin
         rdata_d = lo_q[0];
      end else if (reg_addr_in == DTC_ADDR_B_LO) begin
         rdata_d = lo_q[1];
      end else if (reg_addr_in == DTC_ADDR_A_HI) begin
         rdata_d = hi_q[0];
      end else if (reg_addr_in == DTC_ADDR_B_HI) begin
         rdata_d = hi_q[1];
      end else begin
         rdata_d = DTC_RST_BYTE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mc_cnt_q <= 4'h0;
         ctrl_q   <= DTC_RST_BYTE;
         mode_q   <= DTC_RST_BYTE;
         lo_q[0]  <= DTC_RST_BYTE;
         lo_q[1]  <= DTC_RST_BYTE;
         hi_q[0]  <= DTC_RST_BYTE;
         hi_q[1]  <= DTC_RST_BYTE;
         cpin_q   <= 2'h0;
         xpin_q   <= 2'h0;
         rdata_q  <= DTC_RST_BYTE;
      end else begin
         mc_cnt_q <= mc_cnt_d;
         ctrl_q   <= ctrl_d;
         mode_q   <= mode_d;
         lo_q     <= lo_d;
         hi_q     <= hi_d;
         cpin_q   <= cpin_d;
         xpin_q   <= xpin_d;
         rdata_q  <= rdata_d;
      end
   end

   assign reg_rdata_out   = rdata_q;
   assign timer_a_ovf_out = ctrl_q[DTC_A_OVF];
   assign timer_b_ovf_out = ctrl_q[DTC_B_OVF];
   assign ext_irq_a_out   = ctrl_q[DTC_XA_FLG];
   assign ext_irq_b_out   = ctrl_q[DTC_XB_FLG];

   ////////////////////////////////////////////////////////////////////////
   // Checks, all on the core clock and idle while reset is held
   chk_b_hold_mode3: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (g_tmr[1].md == DTC_MODE_SPLIT && !lo_wr[1]) |=> $stable(lo_q[1]))
      else $error("timer b moved in mode 3");
   chk_a_gate_stop: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (g_tmr[0].nib[DTC_GATE] && !ext_irq_a_pin_in && !lo_wr[0])
      |=> $stable(lo_q[0]))
      else $error("timer a counted while gated");
   chk_a_run_off: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (!ctrl_q[DTC_A_RUN] && !lo_wr[0]) |=> $stable(lo_q[0]))
      else $error("timer a counted while stopped");
   chk_a_reload: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (g_tmr[0].md == DTC_MODE_RELD8 && tmr_inc[0] &&
       lo_q[0] == DTC_BYTE_MAX && !lo_wr[0])
      |=> (lo_q[0] == $past(hi_q[0]) && ctrl_q[DTC_A_OVF]))
      else $error("timer a reload wrong");
   chk_xa_level: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (!ctrl_q[DTC_XA_TT] && !(reg_wr_in && reg_addr_in == DTC_ADDR_CTRL))
      |=> ext_irq_a_out == !$past(ext_irq_a_pin_in))
      else $error("irq a level flag wrong");
   chk_xb_edge_set: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (ctrl_q[DTC_XB_TT] && xpin_q[1] && !ext_irq_b_pin_in)
      |=> ext_irq_b_out)
      else $error("irq b edge missed");
   // Low byte of timer b moves only on a machine tick or a write
   chk_b_tick_only: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (!mc_tick && !lo_wr[1]) |=> $stable(lo_q[1]))
      else $error("timer b off machine cycle");
   chk_a_ack_clear: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (ack_a_ovf_in && !ovf_evt[0] &&
       !(reg_wr_in && reg_addr_in == DTC_ADDR_CTRL)) |=> !timer_a_ovf_out)
      else $error("timer a flag not cleared");
   chk_b_ack_clear: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (ack_b_ovf_in && !tmr_inc[1] && !ahi_inc &&
       !(reg_wr_in && reg_addr_in == DTC_ADDR_CTRL)) |=> !timer_b_ovf_out)
      else $error("timer b flag not cleared");
   chk_b_split_flag: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (ahi_inc && hi_q[0] == DTC_BYTE_MAX) |=> timer_b_ovf_out)
      else $error("split high byte wrap missed");
   chk_xa_edge_clear: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (ctrl_q[DTC_XA_TT] && ack_xa_in &&
       !(xpin_q[0] && !ext_irq_a_pin_in) &&
       !(reg_wr_in && reg_addr_in == DTC_ADDR_CTRL)) |=> !ext_irq_a_out)
      else $error("irq a edge flag not cleared");
endmodule : dtc_top
